// *** core/ebp_pkg.sv ***
// Package: register map, field layout and types of the bridge PWM block
package ebp_pkg;
  localparam int          REG_AW          = 3;
  localparam int          REG_DW          = 8;
  // Register offsets
  localparam logic [2:0]  OFF_DUTY_HIGH   = 3'h0;
  localparam logic [2:0]  OFF_PWM_CTRL    = 3'h1;
  localparam logic [2:0]  OFF_PERIOD      = 3'h2;
  localparam logic [2:0]  OFF_TIMER       = 3'h3;
  localparam logic [2:0]  OFF_TIMER_CTRL  = 3'h4;
  localparam logic [2:0]  OFF_DEADBAND    = 3'h5;
  localparam logic [2:0]  OFF_DUTY_BUF    = 3'h6;
  // Field positions
  localparam int          CTL_DIR_BIT     = 7;
  localparam int          CTL_CFG_HI      = 7;
  localparam int          CTL_CFG_LO      = 6;
  localparam int          CTL_DLOW_HI     = 5;
  localparam int          CTL_DLOW_LO     = 4;
  localparam int          CTL_MODE_HI     = 3;
  localparam int          CTL_MODE_LO     = 0;
  localparam int          TCON_ON_BIT     = 2;
  localparam int          TCON_PS_HI      = 1;
  localparam int          TCON_PS_LO      = 0;
  // Reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [6:0]  RST_DEADBAND    = 7'h00;
  localparam logic [1:0]  RST_FINE        = 2'h0;
  // Prescale: last sub-count index for 1, 4, 16 oscillator clocks per fine step
  localparam logic [3:0]  PS_LAST_1       = 4'h0;
  localparam logic [3:0]  PS_LAST_4       = 4'h3;
  localparam logic [3:0]  PS_LAST_16      = 4'hf;
  localparam logic [1:0]  FINE_LAST       = 2'h3;
  // Oscillator clocks per instruction cycle (dead-band unit)
  localparam int          OSC_PER_INSTR   = 4;
  localparam logic [8:0]  DB_CNT_MAX      = 9'h1ff;
  localparam logic [3:0]  MODE_PWM_HI     = 4'hc;

  typedef enum logic [1:0] {
    EBP_CFG_SINGLE  = 2'b00,
    EBP_CFG_FB_FWD  = 2'b01,
    EBP_CFG_HALF    = 2'b10,
    EBP_CFG_FB_REV  = 2'b11
  } ebp_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ebp_quad_t;

  typedef struct packed {
    ebp_quad_t level;
    ebp_quad_t oe;
  } ebp_bridge_t;
endpackage

// *** core/ebp_bridge_pwm.sv ***
// Enhanced bridge PWM: period timer, buffered duty compare, bridge output steering
//
// Notes on behaviour
// R1 - Duty writes anytime, buffered at period match
// R2 - Duty buffer read-only in PWM mode
// R3 - Clear output when buffer matches timer fine
// R4 - Duty beyond period never clears output
// R5 - Four output configurations selectable
// R6 - Period is 4 Tosc times (limit+1) times prescale
// R7 - Duty time is Tosc times 10-bit duty times prescale
// R8 - Dead-band is 4 Tosc times 7-bit count
// R9 - Half-bridge: A is PWM, B complement
// R10 - Half-bridge delays every inactive-to-active edge
// R11 - Dead-band beyond duty keeps output inactive
// R12 - Forward: A active, D modulated, B C off
// R13 - Reverse: C active, B modulated, A D off
// R14 - Direction write applies next PWM cycle
// R15 - Direction change: B D off, swap A C early
// R16 - Modulated outputs off until period starts
// R17 - Prescale 1, 4 or 16 from two bits
// R18 - Full-bridge never inserts dead-band
// R19 - Firmware lowers duty before reversing near full
// R20 - Config codes: single, forward, half, reverse
// R21 - Modes 1100-1111 select PWM with pair polarity
// R22 - Period end: clear timer, load duty, set output
// R23 - Settings load at period, dead-band at first boundary
`timescale 1ns/1ps
module ebp_bridge_pwm (
  input  wire logic                         ref_clk,
  input  wire logic                         srst,
  input  wire logic [ebp_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [ebp_pkg::REG_DW-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [ebp_pkg::REG_DW-1:0]   reg_rdata,
  output ebp_pkg::ebp_bridge_t              bridge_out
);
  import ebp_pkg::*;

  logic [7:0]  duty_high_byte_r;
  logic [7:0]  pwm_control_reg_r;
  logic [7:0]  period_limit_r;
  logic [7:0]  period_timer_r;
  logic [2:0]  timer_control_reg_r;
  logic [6:0]  deadband_count_r;
  logic [7:0]  duty_compare_buffer_r;
  logic [1:0]  duty_latch_r;
  logic [1:0]  act_cfg_r;
  logic [3:0]  act_mode_r;
  logic [6:0]  db_shadow_r;
  logic [3:0]  sub_r;
  logic [1:0]  fine_r;
  logic        pwm_raw_r;
  logic        raw_dly_r;
  logic [8:0]  db_cnt_r;
  ebp_bridge_t out_r;
  ebp_bridge_t out_nxt;
  logic [7:0]  rdata_r;

  logic        timer_on;
  logic [3:0]  ps_last;
  logic        fine_step;
  logic        tick;
  logic        period_end;
  logic        duty_match;
  logic [9:0]  duty_new;
  logic        pwm_mode;
  logic        pwm_mode_new;
  logic        full_act;
  logic        full_new;
  logic        new_dir;
  logic        swap_win;
  logic        raw_edge;
  logic [8:0]  db_need;
  logic        a_on;
  logic        b_on;
  ebp_quad_t   act;
  logic        buf_wr;

  assign timer_on     = timer_control_reg_r[TCON_ON_BIT];
  assign duty_new     = {duty_high_byte_r, pwm_control_reg_r[CTL_DLOW_HI:CTL_DLOW_LO]};
  assign pwm_mode     = (act_mode_r & MODE_PWM_HI) == MODE_PWM_HI;
  assign pwm_mode_new = (pwm_control_reg_r[CTL_MODE_HI:CTL_MODE_LO] & MODE_PWM_HI) == MODE_PWM_HI;
  assign buf_wr       = reg_wr && reg_addr == OFF_DUTY_BUF && !pwm_mode_new;

  // Prescale select: 00 -> 1, 01 -> 4, 1x -> 16
  always_comb begin
    case (timer_control_reg_r[TCON_PS_HI:TCON_PS_LO])
      2'b00:   ps_last = PS_LAST_1; // [R17]
      2'b01:   ps_last = PS_LAST_4; // [R17]
      default: ps_last = PS_LAST_16; // [R17]
    endcase
  end

  // Fine count advances every prescale clocks; four fine steps make one timer count
  assign fine_step  = timer_on && sub_r == ps_last;
  assign tick       = fine_step && fine_r == FINE_LAST;
  assign period_end = tick && period_timer_r == period_limit_r; // [R6]
  // Match on the step that reaches the duty, so the raw pulse lasts exactly duty fine steps
  // A duty above the period never reaches this equality [R4]
  assign duty_match = fine_step
                      && {duty_compare_buffer_r, duty_latch_r} == {period_timer_r, fine_r} + 10'h001; // [R3] [R7]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sub_r          <= 4'h0;
      fine_r         <= RST_FINE;
      period_timer_r <= RST_BYTE;
    end else if (fine_step) begin
      sub_r  <= 4'h0;
      fine_r <= fine_r + 2'h1;
      if (period_end) begin
        period_timer_r <= RST_BYTE; // [R22]
      end else if (tick) begin
        period_timer_r <= period_timer_r + 8'h01;
      end
    end else if (timer_on) begin
      sub_r <= sub_r + 4'h1;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      duty_high_byte_r    <= RST_BYTE;
      pwm_control_reg_r   <= RST_BYTE;
      period_limit_r      <= RST_BYTE;
      timer_control_reg_r <= 3'h0;
      deadband_count_r    <= RST_DEADBAND;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_DUTY_HIGH:  duty_high_byte_r    <= reg_wdata; // [R1]
        OFF_PWM_CTRL:   pwm_control_reg_r   <= reg_wdata; // [R1] [R14]
        OFF_PERIOD:     period_limit_r      <= reg_wdata;
        OFF_TIMER_CTRL: timer_control_reg_r <= reg_wdata[2:0];
        OFF_DEADBAND:   deadband_count_r    <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  // Duty double buffer; hardware load at the boundary beats a software write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      duty_compare_buffer_r <= RST_BYTE;
      duty_latch_r          <= 2'h0;
    end else if (period_end) begin
      duty_compare_buffer_r <= duty_high_byte_r; // [R1] [R22]
      duty_latch_r          <= pwm_control_reg_r[CTL_DLOW_HI:CTL_DLOW_LO];
    end else if (buf_wr) begin
      duty_compare_buffer_r <= reg_wdata; // [R2]
    end
  end

  // Control shadows; outputs stay idle until the first period boundary
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      act_cfg_r  <= EBP_CFG_SINGLE;
      act_mode_r <= 4'h0;
    end else if (period_end) begin
      act_cfg_r  <= pwm_control_reg_r[CTL_CFG_HI:CTL_CFG_LO]; // [R14] [R23]
      act_mode_r <= pwm_control_reg_r[CTL_MODE_HI:CTL_MODE_LO]; // [R23]
    end
  end

  // Dead-band shadow loads at whichever boundary comes first
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      db_shadow_r <= RST_DEADBAND;
    end else if (period_end || duty_match) begin
      db_shadow_r <= deadband_count_r; // [R23]
    end
  end

  // Raw PWM: set at period end unless duty is zero, cleared on compare match
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwm_raw_r <= 1'b0;
    end else if (period_end) begin
      pwm_raw_r <= duty_new != 10'h000; // [R22]
    end else if (duty_match) begin
      pwm_raw_r <= 1'b0; // [R3]
    end
  end

  // Dead-band timer counts oscillator clocks since the last raw edge
  assign raw_edge = pwm_raw_r != raw_dly_r;
  assign db_need  = 9'({db_shadow_r, 2'b00}); // [R8]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      raw_dly_r <= 1'b0;
      db_cnt_r  <= 9'h000;
    end else begin
      raw_dly_r <= pwm_raw_r;
      if (raw_edge) begin
        db_cnt_r <= 9'h001;
      end else if (db_cnt_r != DB_CNT_MAX) begin
        db_cnt_r <= db_cnt_r + 9'h001;
      end
    end
  end

  // A short pulse ends before the count expires, so that output never turns on
  always_comb begin
    a_on = pwm_raw_r && (raw_edge ? db_need == 9'h000 : db_cnt_r >= db_need); // [R10] [R11]
    b_on = !pwm_raw_r && (raw_edge ? db_need == 9'h000 : db_cnt_r >= db_need); // [R9] [R10] [R11]
  end

  // Direction reversal pending: last timer count of the period
  assign full_act = act_cfg_r[0];
  assign full_new = pwm_control_reg_r[CTL_CFG_LO];
  assign new_dir  = pwm_control_reg_r[CTL_DIR_BIT];
  assign swap_win = pwm_mode && full_act && full_new && new_dir != act_cfg_r[1]
                    && timer_on && period_timer_r == period_limit_r; // [R15] [R16]

  always_comb begin
    act = '0;
    case (ebp_cfg_t'(act_cfg_r))
      EBP_CFG_SINGLE: act.a = pwm_raw_r; // [R5] [R20]
      EBP_CFG_HALF: begin
        act.a = a_on; // [R9]
        act.b = b_on; // [R9]
      end
      EBP_CFG_FB_FWD: begin
        act.a = 1'b1; // [R12] [R18]
        act.d = pwm_raw_r; // [R12]
      end
      EBP_CFG_FB_REV: begin
        act.c = 1'b1; // [R13] [R18]
        act.b = pwm_raw_r; // [R13]
      end
      default: act = '0;
    endcase
    if (swap_win) begin
      act.b = 1'b0; // [R15] [R16]
      act.d = 1'b0; // [R15] [R16]
      act.a = !new_dir; // [R15]
      act.c = new_dir; // [R15]
    end
  end

  // Polarity per pair; pins unused by the configuration stay released and low
  always_comb begin
    out_nxt = '0;
    if (pwm_mode) begin
      out_nxt.oe.a    = 1'b1;
      out_nxt.oe.b    = act_cfg_r != EBP_CFG_SINGLE;
      out_nxt.oe.c    = full_act;
      out_nxt.oe.d    = full_act;
      out_nxt.level.a = act.a ^ act_mode_r[1]; // [R21]
      out_nxt.level.c = full_act && (act.c ^ act_mode_r[1]); // [R21]
      out_nxt.level.b = (act_cfg_r != EBP_CFG_SINGLE) && (act.b ^ act_mode_r[0]); // [R21]
      out_nxt.level.d = full_act && (act.d ^ act_mode_r[0]); // [R21]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_r <= RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_DUTY_HIGH:  rdata_r <= duty_high_byte_r;
        OFF_PWM_CTRL:   rdata_r <= pwm_control_reg_r;
        OFF_PERIOD:     rdata_r <= period_limit_r;
        OFF_TIMER:      rdata_r <= period_timer_r;
        OFF_TIMER_CTRL: rdata_r <= {5'h00, timer_control_reg_r};
        OFF_DEADBAND:   rdata_r <= {1'b0, deadband_count_r};
        OFF_DUTY_BUF:   rdata_r <= duty_compare_buffer_r;
        default:        rdata_r <= RST_BYTE;
      endcase
    end else begin
      rdata_r <= RST_BYTE;
    end
  end

  assign reg_rdata  = rdata_r;
  assign bridge_out = out_r;

  a_buf_load: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
    period_end |=> duty_compare_buffer_r == $past(duty_high_byte_r) && duty_latch_r == $past(duty_new[1:0]))
    else $error("duty buffer not loaded at period end");

  a_buf_readonly: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
    reg_wr && reg_addr == OFF_DUTY_BUF && pwm_mode_new && !period_end |=> $stable(duty_compare_buffer_r))
    else $error("duty buffer written in PWM mode");

  a_match_clear: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
    duty_match && !period_end |=> !pwm_raw_r)
    else $error("output not cleared on duty match");

  a_period_set: assert property (@(posedge ref_clk) disable iff (srst) // [R22]
    period_end |=> pwm_raw_r == ($past(duty_new) != 10'h000) && period_timer_r == 8'h00)
    else $error("period boundary did not restart cycle");

  a_fine_rate: assert property (@(posedge ref_clk) disable iff (srst || (reg_wr && reg_addr == OFF_TIMER_CTRL)) // [R17]
    fine_step && timer_control_reg_r[1:0] == 2'b01 && !reg_wr |=> !fine_step [*3] ##1 fine_step)
    else $error("fine step spacing wrong for prescale four");

  a_fwd_outputs: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    pwm_mode && act_cfg_r == EBP_CFG_FB_FWD && !swap_win
    |=> out_r.level.a == !$past(act_mode_r[1]) && out_r.level.b == $past(act_mode_r[0])
        && out_r.level.c == $past(act_mode_r[1]))
    else $error("forward bridge outputs wrong");

  a_rev_outputs: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
    pwm_mode && act_cfg_r == EBP_CFG_FB_REV && !swap_win
    |=> out_r.level.c == !$past(act_mode_r[1]) && out_r.level.a == $past(act_mode_r[1])
        && out_r.level.d == $past(act_mode_r[0]))
    else $error("reverse bridge outputs wrong");

  a_swap_quiet: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
    swap_win |=> out_r.level.b == $past(act_mode_r[0]) && out_r.level.d == $past(act_mode_r[0])
                 && out_r.level.c == ($past(new_dir) ^ $past(act_mode_r[1])))
    else $error("direction swap window outputs wrong");

  a_half_delay: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    pwm_mode && act_cfg_r == EBP_CFG_HALF && $rose(pwm_raw_r) && db_shadow_r != 7'h00
    |-> !a_on ##1 !a_on ##1 !a_on ##1 !a_on)
    else $error("half-bridge turned on inside dead-band");
endmodule

// *** dv/ebp_drv_model.sv ***
// Bridge switch driver model: counts cycles with both switches of one leg on
`timescale 1ns/1ps
module ebp_drv_model
  import ebp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire ebp_bridge_t bridge_out,
  input  wire logic        pol_ac,
  input  wire logic        pol_bd,
  output logic [15:0]      shoot_cnt
);
  logic sw_a, sw_b, sw_c, sw_d;
  // Undriven pin never turns its switch on
  assign sw_a = bridge_out.oe.a & (bridge_out.level.a ^ pol_ac);
  assign sw_c = bridge_out.oe.c & (bridge_out.level.c ^ pol_ac);
  assign sw_b = bridge_out.oe.b & (bridge_out.level.b ^ pol_bd);
  assign sw_d = bridge_out.oe.d & (bridge_out.level.d ^ pol_bd);
  // Top and bottom of one leg on together shorts the supply
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shoot_cnt <= 16'h0000;
    end else if ((sw_a & sw_b) | (sw_c & sw_d)) begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule

// *** dv/tb_enhanced_bridge_pwm.sv ***
// Self-checking bench for the bridge PWM block
`timescale 1ns/1ps
module tb_enhanced_bridge_pwm;
  import ebp_pkg::*;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic [REG_AW-1:0] reg_addr = 3'h0;
  logic [REG_DW-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  ebp_bridge_t       bridge_out;
  logic              pol_ac = 1'b0;
  logic              pol_bd = 1'b0;
  logic [15:0]       shoot_cnt;
  logic [7:0]        rv;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                ca, cb, cc, cd;
  int                sh0;
  int                shoot_sum = 0;

  ebp_bridge_pwm i_ebp_bridge_pwm (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bridge_out(bridge_out));
  ebp_drv_model i_ebp_drv_model (.ref_clk(ref_clk), .srst(srst), .bridge_out(bridge_out), .pol_ac(pol_ac),
    .pol_bd(pol_bd), .shoot_cnt(shoot_cnt));

  always #25 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard well above the total of all scenarios
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Program a setting, let the shadows settle, then count level highs over four periods
  task automatic run(input logic [7:0] ctl, input logic [7:0] pl, input int duty, input logic [7:0] tcon,
                     input logic [6:0] db, input int per);
    wr(OFF_PERIOD, pl);
    wr(OFF_DUTY_HIGH, duty[9:2]);
    wr(OFF_DEADBAND, {1'b0, db});
    wr(OFF_PWM_CTRL, {ctl[7:6], duty[1:0], ctl[3:0]});
    wr(OFF_TIMER_CTRL, tcon);
    repeat (3 * per + 4) @(posedge ref_clk);
    // Driver polarity follows the settled mode; shoot-through counted only in the window
    pol_ac = ctl[1];
    pol_bd = ctl[0];
    #1;
    sh0 = shoot_cnt;
    {ca, cb, cc, cd} = '0;
    repeat (4 * per) begin
      @(posedge ref_clk);
      #1;
      ca += bridge_out.level.a;
      cb += bridge_out.level.b;
      cc += bridge_out.level.c;
      cd += bridge_out.level.d;
    end
    shoot_sum += shoot_cnt - sh0;
  endtask

  task automatic t_regs();
    rd(OFF_PWM_CTRL, rv);
    check(rv, 8'h00, "ctrl reset");
    rd(OFF_DUTY_BUF, rv);
    check(rv, 8'h00, "duty buffer reset");
    wr(OFF_DEADBAND, 8'hff);
    rd(OFF_DEADBAND, rv);
    check(rv, 8'h7f, "deadband bit7");
    wr(OFF_TIMER, 8'h5a);
    rd(OFF_TIMER, rv);
    check(rv, 8'h00, "timer read-only");
    wr(3'h7, 8'h33);
    rd(3'h7, rv);
    check(rv, 8'h00, "unmapped");
    check(bridge_out, 8'h00, "outputs off outside pwm");
  endtask

  // Period 4*P*(pl+1), active time P*duty, with P from the prescale code
  task automatic t_single(input logic [7:0] tcon, input int p, input int duty);
    int per;
    int hi;
    per = 4 * p * 4;
    hi = (p * duty > per) ? per : p * duty;
    run(8'h0c, 8'h03, duty, tcon, 7'h00, per);
    check(ca, 4 * hi, "single active time");
    check(bridge_out.oe, 4'b1000, "single enables");
  endtask

  task automatic t_half(input int duty, input logic [6:0] db);
    int ea;
    int eb;
    ea = duty - 4 * db;
    eb = 32 - duty - 4 * db;
    run(8'h8c, 8'h07, duty, 8'h04, db, 32);
    check(ca, 4 * ((ea > 0) ? ea : 0), "half A time");
    check(cb, 4 * ((eb > 0) ? eb : 0), "half B time");
    check(bridge_out.oe, 4'b1100, "half enables");
  endtask

  // Counts are active times; inverted pairs show the complement
  task automatic t_full(input logic [7:0] ctl, input int a, input int b, input int c, input int d);
    run(ctl, 8'h03, 6, 8'h04, 7'h05, 16);
    check(ca, ctl[1] ? 64 - a : a, "full A");
    check(cb, ctl[0] ? 64 - b : b, "full B");
    check(cc, ctl[1] ? 64 - c : c, "full C");
    check(cd, ctl[0] ? 64 - d : d, "full D");
    check(bridge_out.oe, 4'b1111, "full enables");
  endtask

  task automatic t_dbuf();
    run(8'h0c, 8'h03, 8, 8'h04, 7'h00, 16);
    // Start just after a period boundary so no load falls between write and read
    @(posedge bridge_out.level.a);
    wr(OFF_DUTY_HIGH, 8'h03);
    rd(OFF_DUTY_BUF, rv);
    check(rv, 8'h02, "buffer holds old duty");
    wr(OFF_DUTY_BUF, 8'haa);
    repeat (40) @(posedge ref_clk);
    rd(OFF_DUTY_BUF, rv);
    check(rv, 8'h03, "buffer loaded, write refused");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_single(8'h04, 1, 6);
    t_single(8'h05, 4, 9);
    t_single(8'h06, 16, 16);
    t_single(8'h07, 16, 3);
    t_single(8'h04, 1, 0);
    t_single(8'h04, 1, 20);
    t_half(16, 7'h00);
    t_half(16, 7'h02);
    t_half(24, 7'h05);
    t_full(8'h4c, 64, 0, 0, 24);
    // Duty stays far from full across the reversal
    t_full(8'hcc, 0, 24, 64, 0);
    t_full(8'h4f, 64, 0, 0, 24);
    t_full(8'hcd, 0, 24, 64, 0);
    t_full(8'h4e, 64, 0, 0, 24);
    t_dbuf();
    check(shoot_sum, 16'h0000, "leg shoot-through");
    tally_and_finish();
  end
endmodule
